// >>> logic/b3c_pkg.sv
// Constants, register map and types for the regulator 3 command-register control block
// Operation
// - Mode field 00 pulse-skipping (default), 01 low-power burst, 10 forced continuous.
// - Enable waits for output below 300mV when wait bit is 0, else immediate.
// - Variant strap inverts wait bit: 0 enables immediately, 1 waits for 300mV.
// - Reference-select bit 0 uses target A, 1 uses target B.
// - Host writes 1 to slew-trigger bit; device then slews toward selected target.
// - Slew rate codes 00..11 give 0.88, 1.75, 3.5, 7 mV/us; default 11.
// - While slewing, power-good forced low if mask bit 0, normal if 1.
// - Two independent 5-bit target codes, each resetting to 11001.
// - Switch at 2.25MHz; frequency-select bit high drops to 1.125MHz.
// - Phase bit delays switching cycle start 20% at full rate, 50% at half.
// - Keep-alive bit 0 shuts down normally; 1 keeps regulator running in shutdown.
// - Every enable, also after fault, soft-starts from 0V at 0.8V/ms.
// - Soft-start forces pulse-skipping regardless of mode field.
package b3c_pkg;
  localparam int CLK_NS = 25;
  localparam int CLK_KHZ = 40000;
  localparam int US_NS = 1000;
  localparam int TICK_CYC = US_NS / CLK_NS;
  localparam int FSW_FULL_KHZ = 2250;
  localparam int SW_FULL_CYC = CLK_KHZ / FSW_FULL_KHZ;
  localparam int SW_HALF_CYC = 2 * SW_FULL_CYC;
  localparam int PHASE_FULL_PCT = 20;
  localparam int PHASE_HALF_PCT = 50;
  localparam int SW_CNT_W = 6;

  // Wide enough that the top DAC codes do not wrap past 1.048V
  localparam int UV_W = 21;
  // Reference voltages in microvolts; steps are per microsecond tick
  localparam logic [UV_W-1:0] SOFT_STEP_UV = 21'h000320;
  localparam logic [UV_W-1:0] SLEW_STEP_UV0 = 21'h000370;
  localparam logic [UV_W-1:0] SLEW_STEP_UV1 = 21'h0006D6;
  localparam logic [UV_W-1:0] SLEW_STEP_UV2 = 21'h000DAC;
  localparam logic [UV_W-1:0] SLEW_STEP_UV3 = 21'h001B58;
  // DAC mapping of the 5-bit code; plain defaults
  localparam logic [UV_W-1:0] DAC_BASE_UV = 21'h061A80;
  localparam logic [UV_W-1:0] DAC_LSB_UV = 21'h0061A8;

  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_OUT_EN = 3'h1;
  localparam logic [2:0] ADDR_WAIT = 3'h2;
  localparam logic [2:0] ADDR_VCHG = 3'h3;
  localparam logic [2:0] ADDR_RATE = 3'h4;
  localparam logic [2:0] ADDR_TGT_A = 3'h5;
  localparam logic [2:0] ADDR_TGT_B = 3'h6;
  localparam logic [2:0] ADDR_STATUS = 3'h7;

  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_OUT_EN = 8'h00;
  localparam logic [7:0] RST_WAIT = 8'h00;
  localparam logic [7:0] RST_VCHG = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h3F;
  localparam logic [7:0] RST_TGT = 8'h19;

  localparam int MODE_LSB = 4;
  localparam int OUT_EN_BIT = 2;
  localparam int WAIT_BIT = 2;
  localparam int SEL_BIT = 5;
  localparam int GO_BIT = 4;
  localparam int RATE_LSB = 4;
  localparam int PG_MASK_BIT = 5;
  localparam int FREQ_BIT = 5;
  localparam int PHASE_BIT = 6;
  localparam int ALIVE_BIT = 7;

  typedef enum logic [1:0] {
    MODE_PULSE_SKIP = 2'b00,
    MODE_BURST = 2'b01,
    MODE_CONTINUOUS = 2'b10
  } b3c_mode_e;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_WAIT_LOW = 2'b01,
    ST_SOFT = 2'b10,
    ST_ON = 2'b11
  } b3c_state_e;
endpackage

// >>> logic/b3c_ramp_if.sv
// Interface between the control top and the reference ramp generator
`timescale 1ns/1ps
interface b3c_ramp_if;
  import b3c_pkg::*;
  logic tick;
  logic active;
  logic zero;
  logic [UV_W-1:0] step;
  logic [UV_W-1:0] target;
  logic [UV_W-1:0] ref_uv;
  logic at_target;
  modport ctrl (output tick, active, zero, step, target, input ref_uv, at_target);
  modport ramp (input tick, active, zero, step, target, output ref_uv, at_target);
endinterface

// >>> logic/b3c_ramp.sv
// Reference ramp generator: steps the reference toward a target once per tick
`timescale 1ns/1ps
module b3c_ramp
  import b3c_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  b3c_ramp_if.ramp r
);
  logic [UV_W-1:0] ref_q;
  logic [UV_W-1:0] ref_d;

  always_comb begin
    ref_d = ref_q;
    if (r.zero) begin
      ref_d = '0;
    end else if (r.active && r.tick) begin
      // Clamp the last step so the reference lands on the target exactly
      if (ref_q < r.target) begin
        ref_d = (r.target - ref_q > r.step) ? ref_q + r.step : r.target;
      end else if (ref_q > r.target) begin
        ref_d = (ref_q - r.target > r.step) ? ref_q - r.step : r.target;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ref_q <= '0;
    end else begin
      ref_q <= ref_d;
    end
  end

  assign r.ref_uv = ref_q;
  assign r.at_target = (ref_q == r.target);
endmodule

// >>> logic/b3c_top.sv
// Regulator 3 command registers, enable sequencing, slew and switching-clock control
`timescale 1ns/1ps
module b3c_top
  import b3c_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic REG_WR_EN,
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic OUT_BELOW_300MV,
  input wire logic VARIANT_INVERT_WAIT,
  input wire logic SYS_SHUTDOWN,
  input wire logic FAULT,
  input wire logic POWER_GOOD_OUT_SENSE,
  output logic REG_RUN,
  output logic [1:0] MODE_OUT,
  output logic [UV_W-1:0] REF_UV,
  output logic SLEWING,
  output logic SOFT_STARTING,
  output logic FREQ_HALF,
  output logic SW_CYCLE_START,
  output logic POWER_GOOD_OUT
);
  b3c_ramp_if rif ();

  b3c_ramp u_ramp (
    .clk(CLK),
    .reset_n(RESET_N),
    .r(rif.ramp)
  );

  function automatic logic [UV_W-1:0] dac_uv(input logic [4:0] code);
    dac_uv = DAC_BASE_UV + DAC_LSB_UV * {{(UV_W-5){1'b0}}, code};
  endfunction

  function automatic logic [UV_W-1:0] rate_step(input logic [1:0] code);
    unique case (code)
      2'b00: rate_step = SLEW_STEP_UV0;
      2'b01: rate_step = SLEW_STEP_UV1;
      2'b10: rate_step = SLEW_STEP_UV2;
      2'b11: rate_step = SLEW_STEP_UV3;
    endcase
  endfunction

  // Two-flop synchronisers for the pin-side levels
  logic [4:0] sync1_q, sync2_q, sync1_d, sync2_d;
  logic below_s, invert_s, shut_s, fault_s, pg_s;
  assign sync1_d = {POWER_GOOD_OUT_SENSE, FAULT, SYS_SHUTDOWN, VARIANT_INVERT_WAIT, OUT_BELOW_300MV};
  assign sync2_d = sync1_q;
  assign {pg_s, fault_s, shut_s, invert_s, below_s} = sync2_q;

  // Register file
  logic [7:0] mode_q, mode_d, oen_q, oen_d, wait_q, wait_d, vchg_q, vchg_d;
  logic [7:0] rate_q, rate_d, tga_q, tga_d, tgb_q, tgb_d, rdata_q, rdata_d;
  logic go_q, go_d;
  b3c_state_e st_q, st_d;
  logic [SW_CNT_W-1:0] cnt_q, cnt_d;
  logic swp_q, swp_d;

  logic wr_vchg, go_set, wait_eff, run_req, half, sel_b;
  logic [SW_CNT_W-1:0] period, offset;
  logic [UV_W-1:0] sel_target;
  logic [1:0] mode_field;
  logic [5:0] us_q, us_d;
  logic us_tick;

  assign wr_vchg = REG_WR_EN && (REG_ADDR == ADDR_VCHG);
  assign go_set = wr_vchg && REG_WDATA[GO_BIT];
  assign sel_b = vchg_q[SEL_BIT];
  assign sel_target = sel_b ? dac_uv(tgb_q[4:0]) : dac_uv(tga_q[4:0]);
  // Clear wait bit means wait for discharge, unless the variant strap flips it
  assign wait_eff = !(wait_q[WAIT_BIT] ^ invert_s);
  // Keep-alive lets the regulator ride through a system shutdown
  assign run_req = oen_q[OUT_EN_BIT] && !fault_s && !(shut_s && !tgb_q[ALIVE_BIT]);
  assign half = tgb_q[FREQ_BIT];
  assign period = half ? SW_CNT_W'(SW_HALF_CYC) : SW_CNT_W'(SW_FULL_CYC);
  assign offset = !tgb_q[PHASE_BIT] ? '0 :
                  half ? SW_CNT_W'(SW_HALF_CYC * PHASE_HALF_PCT / 100) :
                         SW_CNT_W'(SW_FULL_CYC * PHASE_FULL_PCT / 100);
  assign mode_field = mode_q[MODE_LSB +: 2];

  always_comb begin
    mode_d = mode_q;
    oen_d = oen_q;
    wait_d = wait_q;
    vchg_d = vchg_q;
    rate_d = rate_q;
    tga_d = tga_q;
    tgb_d = tgb_q;
    if (REG_WR_EN) begin
      unique case (REG_ADDR)
        ADDR_MODE: mode_d = REG_WDATA;
        ADDR_OUT_EN: oen_d = REG_WDATA;
        ADDR_WAIT: wait_d = REG_WDATA;
        ADDR_VCHG: vchg_d = REG_WDATA;
        ADDR_RATE: rate_d = REG_WDATA;
        ADDR_TGT_A: tga_d = REG_WDATA;
        ADDR_TGT_B: tgb_d = REG_WDATA;
        ADDR_STATUS: ;
      endcase
    end
    rdata_d = 8'h00;
    unique case (REG_ADDR)
      ADDR_MODE: rdata_d = mode_q;
      ADDR_OUT_EN: rdata_d = oen_q;
      ADDR_WAIT: rdata_d = wait_q;
      ADDR_VCHG: rdata_d = {vchg_q[7:5], go_q, vchg_q[3:0]};
      ADDR_RATE: rdata_d = rate_q;
      ADDR_TGT_A: rdata_d = tga_q;
      ADDR_TGT_B: rdata_d = tgb_q;
      ADDR_STATUS: rdata_d = {4'h0, rif.at_target, go_q, st_q};
    endcase
  end

  // Enable sequencing: off, wait for discharge, soft-start, on
  always_comb begin
    st_d = st_q;
    go_d = go_q;
    if (!run_req) begin
      st_d = ST_OFF;
    end else begin
      unique case (st_q)
        ST_OFF: st_d = wait_eff ? ST_WAIT_LOW : ST_SOFT;
        ST_WAIT_LOW: if (below_s) st_d = ST_SOFT;
        ST_SOFT: if (rif.at_target) st_d = ST_ON;
        ST_ON: ;
      endcase
    end
    // A trigger arriving with the completion still starts a new slew
    if (st_q == ST_OFF || (st_q == ST_ON && go_q && rif.at_target)) begin
      go_d = 1'b0;
    end
    if (go_set) begin
      go_d = 1'b1;
    end
  end

  always_comb begin
    rif.tick = us_tick;
    rif.zero = (st_q != ST_SOFT) && (st_d == ST_SOFT);
    rif.target = sel_target;
    rif.active = (st_q == ST_SOFT) || (st_q == ST_ON && go_q);
    rif.step = (st_q == ST_SOFT) ? SOFT_STEP_UV : rate_step(rate_q[RATE_LSB +: 2]);
  end

  // Microsecond tick divider
  assign us_tick = (us_q == 6'(TICK_CYC - 1));
  assign us_d = us_tick ? '0 : us_q + 6'h01;

  always_comb begin
    cnt_d = '0;
    swp_d = 1'b0;
    if (st_q != ST_OFF && st_q != ST_WAIT_LOW) begin
      cnt_d = (cnt_q >= period - 1'b1) ? '0 : cnt_q + 1'b1;
      swp_d = (cnt_q == offset);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sync1_q <= '0;
      sync2_q <= '0;
      mode_q <= RST_MODE;
      oen_q <= RST_OUT_EN;
      wait_q <= RST_WAIT;
      vchg_q <= RST_VCHG;
      rate_q <= RST_RATE;
      tga_q <= RST_TGT;
      tgb_q <= RST_TGT;
      rdata_q <= 8'h00;
      go_q <= 1'b0;
      st_q <= ST_OFF;
      cnt_q <= '0;
      swp_q <= 1'b0;
      us_q <= '0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      mode_q <= mode_d;
      oen_q <= oen_d;
      wait_q <= wait_d;
      vchg_q <= vchg_d;
      rate_q <= rate_d;
      tga_q <= tga_d;
      tgb_q <= tgb_d;
      rdata_q <= rdata_d;
      go_q <= go_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      swp_q <= swp_d;
      us_q <= us_d;
    end
  end

  logic slewing;
  assign slewing = (st_q == ST_ON) && go_q;

  always_comb begin
    REG_RDATA = rdata_q;
    REG_RUN = (st_q == ST_SOFT) || (st_q == ST_ON);
    // Unused code 11 falls back to pulse-skipping rather than an undefined mode
    if (st_q == ST_SOFT || mode_field == 2'b11) begin
      MODE_OUT = MODE_PULSE_SKIP;
    end else begin
      MODE_OUT = mode_field;
    end
    REF_UV = rif.ref_uv;
    SLEWING = slewing;
    SOFT_STARTING = (st_q == ST_SOFT);
    FREQ_HALF = half;
    SW_CYCLE_START = swp_q;
    POWER_GOOD_OUT = pg_s && (st_q == ST_ON) && !(slewing && !tga_q[PG_MASK_BIT]);
  end
endmodule

// >>> tb/b3c_top_assertions.sv
// Port-level checks for the regulator 3 control top
`timescale 1ns/1ps
module b3c_top_assertions
  import b3c_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic FAULT,
  input wire logic REG_RUN,
  input wire logic [1:0] MODE_OUT,
  input wire logic [UV_W-1:0] REF_UV,
  input wire logic SLEWING,
  input wire logic SOFT_STARTING,
  input wire logic SW_CYCLE_START,
  input wire logic POWER_GOOD_OUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Three cycles deep so the zeroing at soft-start entry has landed
  sequence soft_run;
    SOFT_STARTING [*3];
  endsequence
  sequence slew_run;
    SLEWING ##1 SLEWING;
  endsequence
  AST_SOFT_MODE: assert property (SOFT_STARTING |-> MODE_OUT == 2'b00)
    else $error("mode not pulse-skip in soft-start");
  AST_SOFT_RISE: assert property (soft_run |-> REF_UV >= $past(REF_UV))
    else $error("soft-start reference fell");
  AST_SOFT_STEP: assert property (soft_run |-> REF_UV - $past(REF_UV) <= SOFT_STEP_UV)
    else $error("soft-start step too large");
  AST_SW_GAP: assert property (SW_CYCLE_START |=> !SW_CYCLE_START [*8])
    else $error("switching cycles too close");
  AST_PG_OFF: assert property (!REG_RUN |-> !POWER_GOOD_OUT)
    else $error("power good high while off");
  AST_SLEW_ON: assert property (SLEWING |-> REG_RUN && !SOFT_STARTING)
    else $error("slewing outside on state");
  AST_SLEW_STEP: assert property (slew_run |-> ((REF_UV >= $past(REF_UV)) ?
    REF_UV - $past(REF_UV) : $past(REF_UV) - REF_UV) <= SLEW_STEP_UV3)
    else $error("slew step too large");
  AST_SLEW_HOLD: assert property ($fell(SLEWING) && REG_RUN |-> $stable(REF_UV))
    else $error("reference moved after slew end");
  AST_FAULT_OFF: assert property ($rose(FAULT) |-> ##[1:5] !REG_RUN)
    else $error("fault did not stop regulator");
endmodule

// >>> tb/b3c_host_model.sv
// Host model issuing register writes and reads on the control port
`timescale 1ns/1ps
module b3c_host_model (
  input wire logic CLK,
  input wire logic [7:0] REG_RDATA,
  output logic REG_WR_EN,
  output logic [2:0] REG_ADDR,
  output logic [7:0] REG_WDATA
);
  initial begin
    REG_WR_EN = 1'b0;
    REG_ADDR = 3'h0;
    REG_WDATA = 8'h00;
  end
  // One-cycle strobe; data is scrambled after release so stale bytes are never reused
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR_EN <= 1'b1;
    @(posedge CLK);
    REG_WR_EN <= 1'b0;
    REG_WDATA <= ~d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    repeat (2) @(posedge CLK);
    #1 d = REG_RDATA;
  endtask
endmodule

// >>> tb/b3c_top_tb.sv
// Self-checking bench for the regulator 3 control top
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module b3c_top_tb;
  import b3c_pkg::*;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic OUT_BELOW_300MV = 1'b0;
  logic VARIANT_INVERT_WAIT = 1'b0;
  logic SYS_SHUTDOWN = 1'b0;
  logic FAULT = 1'b0;
  logic POWER_GOOD_OUT_SENSE = 1'b1;
  wire logic REG_WR_EN;
  wire logic [2:0] REG_ADDR;
  wire logic [7:0] REG_WDATA;
  logic [7:0] REG_RDATA;
  logic REG_RUN, SLEWING, SOFT_STARTING, FREQ_HALF, SW_CYCLE_START, POWER_GOOD_OUT;
  logic [1:0] MODE_OUT;
  logic [UV_W-1:0] REF_UV, obs, e_v;
  logic [UV_W-1:0] exp_q[$];
  logic [7:0] d, v;
  logic [7:0] rst_v[7] = '{RST_MODE, RST_OUT_EN, RST_WAIT, RST_VCHG, RST_RATE, RST_TGT, RST_TGT};
  int stp[4] = '{29, 15, 8, 4};
  int fails = 0;
  int n_compared = 0;
  int n, i;
  integer seed;
  logic pg_hi;
  string what;
  event smp;
  always #12.5 CLK = ~CLK;
  b3c_top b3c_top_i (.CLK(CLK), .RESET_N(RESET_N), .REG_WR_EN(REG_WR_EN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .OUT_BELOW_300MV(OUT_BELOW_300MV),
    .VARIANT_INVERT_WAIT(VARIANT_INVERT_WAIT), .SYS_SHUTDOWN(SYS_SHUTDOWN), .FAULT(FAULT),
    .POWER_GOOD_OUT_SENSE(POWER_GOOD_OUT_SENSE), .REG_RUN(REG_RUN), .MODE_OUT(MODE_OUT), .REF_UV(REF_UV),
    .SLEWING(SLEWING), .SOFT_STARTING(SOFT_STARTING), .FREQ_HALF(FREQ_HALF),
    .SW_CYCLE_START(SW_CYCLE_START), .POWER_GOOD_OUT(POWER_GOOD_OUT));
  b3c_host_model b3c_host_model_i (.CLK(CLK), .REG_RDATA(REG_RDATA), .REG_WR_EN(REG_WR_EN),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA));
  always @(smp) begin
    e_v = exp_q.pop_front();
    `CHK(what, e_v, obs)
  end
  task automatic note(input string w, input logic [UV_W-1:0] e, input logic [UV_W-1:0] o);
    what = w;
    obs = o;
    exp_q.push_back(e);
    ->smp;
    #1;
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge CLK);
    fails++;
    wrap_up();
  end
  initial begin
    seed = 32'hBA48D443;
    repeat (10) @(posedge CLK);
    RESET_N <= 1'b1;
    for (i = 0; i < 7; i++) begin
      b3c_host_model_i.rd(i[2:0], d);
      note("reset", rst_v[i], d);
    end
    b3c_host_model_i.wr(3'h7, 8'hFF);
    b3c_host_model_i.rd(3'h7, d);
    note("status", 0, d);
    repeat (4) begin
      v = 8'($random(seed));
      b3c_host_model_i.wr(ADDR_TGT_A, {3'h0, v[4:0]});
      b3c_host_model_i.rd(ADDR_TGT_A, d);
      note("tgt_a", {3'h0, v[4:0]}, d);
    end
    for (i = 0; i < 3; i++) begin
      b3c_host_model_i.wr(ADDR_MODE, {2'h0, i[1:0], 4'h0});
      b3c_host_model_i.rd(ADDR_MODE, d);
      note("mode_reg", {2'h0, i[1:0], 4'h0}, d);
    end
    b3c_host_model_i.wr(ADDR_TGT_A, 8'h00);
    b3c_host_model_i.wr(ADDR_TGT_B, 8'h01);
    b3c_host_model_i.wr(ADDR_OUT_EN, 8'h04);
    b3c_host_model_i.rd(ADDR_STATUS, d);
    note("wait_state", 1, d[1:0]);
    OUT_BELOW_300MV <= 1'b1;
    for (n = 0; n < 20 && REG_RUN !== 1'b1; n++) @(posedge CLK);
    note("run_low", 1, REG_RUN);
    b3c_host_model_i.wr(ADDR_OUT_EN, 8'h00);
    OUT_BELOW_300MV <= 1'b0;
    VARIANT_INVERT_WAIT <= 1'b1;
    repeat (5) @(posedge CLK);
    b3c_host_model_i.wr(ADDR_OUT_EN, 8'h04);
    for (n = 0; n < 10 && REG_RUN !== 1'b1; n++) @(posedge CLK);
    note("run_inv", 1, REG_RUN);
    for (n = 0; n < 10 && SOFT_STARTING !== 1'b1; n++) @(posedge CLK);
    b3c_host_model_i.wr(ADDR_MODE, 8'h20);
    note("soft_mode", 0, MODE_OUT);
    for (n = 0; n < 25000 && SOFT_STARTING !== 1'b0; n++) @(posedge CLK);
    note("soft_time", 1, n >= 499 * 40 && n <= 501 * 40);
    note("soft_ref", DAC_BASE_UV, REF_UV);
    for (i = 0; i < 3; i++) begin
      b3c_host_model_i.wr(ADDR_MODE, {2'h0, i[1:0], 4'h0});
      repeat (3) @(posedge CLK);
      note("mode_out", i, MODE_OUT);
    end
    for (i = 0; i < 4; i++) begin
      b3c_host_model_i.wr(ADDR_RATE, {2'h0, i[1:0], 4'hF});
      b3c_host_model_i.wr(ADDR_TGT_A, {2'h0, i[0], 5'h00});
      b3c_host_model_i.wr(ADDR_VCHG, {2'h0, ~i[0], 5'h10});
      pg_hi = 1'b0;
      for (n = 0; n < 10 && SLEWING !== 1'b1; n++) @(posedge CLK);
      for (n = 0; n < 2000 && SLEWING !== 1'b0; n++) begin
        @(posedge CLK);
        // Only the cycles still inside the slew count for the mask check
        pg_hi = pg_hi | (POWER_GOOD_OUT && SLEWING);
      end
      note("slew_time", 1, n > (stp[i] - 1) * 40 && n <= (stp[i] + 1) * 40);
      note("slew_ref", i[0] ? DAC_BASE_UV : DAC_BASE_UV + DAC_LSB_UV, REF_UV);
      note("pg_slew", i[0], pg_hi);
    end
    for (i = 0; i < 2; i++) begin
      b3c_host_model_i.wr(ADDR_TGT_B, {2'h0, i[0], 5'h01});
      for (n = 0; n < 80 && SW_CYCLE_START !== 1'b1; n++) @(posedge CLK);
      @(posedge CLK);
      for (n = 1; n < 80 && SW_CYCLE_START !== 1'b1; n++) @(posedge CLK);
      note("sw_period", i[0] ? SW_HALF_CYC : SW_FULL_CYC, n);
      note("freq_half", i[0], FREQ_HALF);
    end
    b3c_host_model_i.wr(ADDR_TGT_B, 8'hA1);
    SYS_SHUTDOWN <= 1'b1;
    repeat (10) @(posedge CLK);
    note("keep_alive", 1, REG_RUN);
    FAULT <= 1'b1;
    repeat (10) @(posedge CLK);
    note("fault_off", 0, REG_RUN);
    b3c_host_model_i.wr(ADDR_TGT_B, 8'h21);
    FAULT <= 1'b0;
    repeat (10) @(posedge CLK);
    note("shut_off", 0, REG_RUN);
    b3c_host_model_i.wr(ADDR_TGT_B, 8'h41);
    SYS_SHUTDOWN <= 1'b0;
    for (n = 0; n < 20 && REG_RUN !== 1'b1; n++) @(posedge CLK);
    for (n = 0; n < 80 && SW_CYCLE_START !== 1'b1; n++) @(posedge CLK);
    note("phase", SW_FULL_CYC * PHASE_FULL_PCT / 100 + 1, n);
    note("refault_soft", 1, SOFT_STARTING);
    wrap_up();
  end
endmodule
bind b3c_top b3c_top_assertions b3c_top_assertions_i (.CLK(CLK), .RESET_N(RESET_N),
  .FAULT(FAULT), .REG_RUN(REG_RUN), .MODE_OUT(MODE_OUT), .REF_UV(REF_UV), .SLEWING(SLEWING),
  .SOFT_STARTING(SOFT_STARTING), .SW_CYCLE_START(SW_CYCLE_START),
  .POWER_GOOD_OUT(POWER_GOOD_OUT));
